// >>> hw/isp_port.sv
// Two-wire serial slave port giving a bus master access to a register map.
// Assumes SCL and SDA arrive from pins with an external pull-up on SDA.
// What this block does
// - Slave only, transmit and receive, 100 kbit/s.
// - Detect START anywhere: SDA falls, SCL high.
// - Detect STOP: SDA rises, SCL high; idle.
// - Busy after START; repeated START restarts address.
// - SDA changes only while SCL is low.
// - Drive SDA only for acknowledge or read data.
// - Eight bits MSB first, then acknowledge bit.
// - Receiver pulls SDA low in ninth clock.
// - Read ends on master NACK; release SDA.
// - First seven bits after START are address.
// - Byte LSB one means read, zero write.
// - Address match: acknowledge, then take direction.
// - Respond to fixed address 0x58.
// - Write: address, register, data, store.
// - Read: set register, restart, send contents.
// - Open-drain SDA, released when idle.
// - No byte count limit per transfer.
`timescale 1ns/1ps
module isp_port
#(
   parameter logic [6:0] ADDR = isp_pkg::SLAVE_ADDR
)
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       CE,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE,
   output logic            BUSY,
   output logic            REG_WSTB,
   output logic [7:0]      REG_ADDR,
   output logic [7:0]      REG_WDATA
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic scl;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic sda_rise;
   logic sda_fall;

   // Both pins pass two flops before any decoding.
   isp_sync u_scl
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .CE    (CE),
      .PIN   (SCL_I),
      .level (scl),
      .rise  (scl_rise),
      .fall  (scl_fall)
   );

   isp_sync u_sda
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .CE    (CE),
      .PIN   (SDA_I),
      .level (sda),
      .rise  (sda_rise),
      .fall  (sda_fall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Condition decode.
   wire start_det = sda_fall & scl;
   wire stop_det  = sda_rise & scl;

   isp_pkg::isp_state_t state;
   logic [3:0]          bit_cnt;
   logic [7:0]          shift;
   logic                drive_low;
   logic                pend_valid;
   logic                pend_val;
   logic [3:0]          hold_cnt;
   logic                master_nack;
   logic                tx_active;
   logic [7:0]          rd_data;
   logic                wstb;
   logic [7:0]          reg_ptr;
   logic                skip_fall;

   // Assembled byte once the eighth bit lands on SCL rise, MSB first.
   wire [7:0] rx_byte   = {shift[6:0], sda};
   wire       addr_hit  = (rx_byte[7:1] == ADDR);
   wire       rd_dir    = rx_byte[0];
   wire       in_data   = (bit_cnt <= isp_pkg::BIT_LAST);
   wire       ack_slot  = (bit_cnt == isp_pkg::BIT_ACK);
   wire       last_bit  = (bit_cnt == isp_pkg::BIT_LAST);

   ////////////////////////////////////////////////////////////////////////
   // Register store.
   isp_regfile u_regs
   (
      .CLK   (CLK),
      .RST_N (RST_N),
      .CE    (CE),
      .we    (wstb),
      .addr  (reg_ptr),
      .wdata (shift),   // Full byte once wstb is up.
      .rdata (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Protocol engine. Bits are taken on SCL rise; the SDA value for the
   // next slot is computed on SCL fall but applied only after a hold delay,
   // so the master never sees our edge inside its SCL-fall window.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         state       <= isp_pkg::ST_IDLE;
         bit_cnt     <= 4'h0;
         shift       <= 8'h00;
         pend_valid  <= 1'b0;
         pend_val    <= 1'b0;
         hold_cnt    <= 4'h0;
         drive_low   <= 1'b0;
         master_nack <= 1'b0;
         tx_active   <= 1'b0;
         wstb        <= 1'b0;
         reg_ptr     <= 8'h00;
         skip_fall   <= 1'b0;
      end
      else if (CE)
      begin
         wstb <= 1'b0;
         if (start_det)
         begin
            // Repeated START behaves exactly as START.
            state      <= isp_pkg::ST_ADDR;
            bit_cnt    <= 4'h0;
            drive_low  <= 1'b0;
            pend_valid <= 1'b0;
            tx_active  <= 1'b0;
            skip_fall  <= 1'b1;
         end
         else if (stop_det)
         begin
            state      <= isp_pkg::ST_IDLE;
            drive_low  <= 1'b0;
            pend_valid <= 1'b0;
            tx_active  <= 1'b0;
         end
         else if (state != isp_pkg::ST_IDLE &&
                  state != isp_pkg::ST_IGN)
         begin
            if (scl_rise)
            begin
               // Each SCL pulse from the master is one bit; the master sets the rate, with SCL low longer than the hold delay.
               if (in_data)
                  shift <= rx_byte;
               if (ack_slot)
                  master_nack <= sda;
               if (last_bit)
               begin
                  case (state)
                     isp_pkg::ST_ADDR:
                     begin
                        if (!addr_hit)
                           state <= isp_pkg::ST_IGN;
                     end
                     isp_pkg::ST_RXREG:
                     begin
                        reg_ptr <= rx_byte;
                     end
                     isp_pkg::ST_RXDAT:
                     begin
                        wstb <= 1'b1;
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
            else if (scl_fall && skip_fall)
            begin
               // The SCL fall that closes a START is not a bit slot, so
               // counting it would make the address one bit short.
               skip_fall <= 1'b0;
            end
            else if (scl_fall)
            begin
               // Advance the slot; the ninth slot wraps back to bit 0.
               bit_cnt <= ack_slot ? 4'h0 : bit_cnt + 4'h1;
               pend_valid <= 1'b1;
               hold_cnt   <= 4'h0;
               if (last_bit)
               begin
                  // Our receiving bytes are acknowledged.
                  pend_val <= (state != isp_pkg::ST_TX);
                  // Step the pointer early so the next byte's data is
                  // already on the store output at the acknowledge fall.
                  if (state == isp_pkg::ST_TX)
                     reg_ptr <= reg_ptr + 8'h01;
               end
               else if (ack_slot)
               begin
                  case (state)
                     isp_pkg::ST_ADDR:
                     begin
                        // Direction chosen by the address byte.
                        state     <= shift[0] ? isp_pkg::ST_TX
                                              : isp_pkg::ST_RXREG;
                        tx_active <= shift[0];
                        pend_val  <= shift[0] & ~rd_data[7];
                        shift     <= shift[0] ? rd_data : shift;
                     end
                     isp_pkg::ST_RXREG:
                     begin
                        state    <= isp_pkg::ST_RXDAT;
                        pend_val <= 1'b0;
                     end
                     isp_pkg::ST_RXDAT:
                     begin
                        reg_ptr  <= reg_ptr + 8'h01;
                        pend_val <= 1'b0;
                     end
                     isp_pkg::ST_TX:
                     begin
                        if (master_nack)
                        begin
                           // NACK ends the read; SDA stays released.
                           state     <= isp_pkg::ST_IGN;
                           tx_active <= 1'b0;
                           pend_val  <= 1'b0;
                        end
                        else
                        begin
                           // Master ACK: keep sending from the next byte.
                           shift    <= rd_data;
                           pend_val <= ~rd_data[7];
                        end
                     end
                     default:
                     begin
                        pend_val <= 1'b0;
                     end
                  endcase
               end
               else
               begin
                  // Read data shifts out MSB first; each rise has moved
                  // the next bit to the top of the shift.
                  pend_val <= tx_active & ~shift[7];
               end
            end
            else if (pend_valid)
            begin
               if (hold_cnt == isp_pkg::HOLD_CYC_W)
               begin
                  drive_low  <= pend_val;
                  pend_valid <= 1'b0;
               end
               else
                  hold_cnt <= hold_cnt + 4'h1;
            end
         end
         else
         begin
            drive_low <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs; SDA is open drain, so we only ever pull low.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         SDA_O     <= 1'b0;
         SDA_OE    <= 1'b0;
         BUSY      <= 1'b0;
         REG_WSTB  <= 1'b0;
         REG_ADDR  <= 8'h00;
         REG_WDATA <= 8'h00;
      end
      else if (CE)
      begin
         SDA_O     <= 1'b0;
         SDA_OE    <= drive_low;
         BUSY      <= (state != isp_pkg::ST_IDLE) | start_det;
         REG_WSTB  <= wstb;
         REG_ADDR  <= reg_ptr;
         REG_WDATA <= shift;
      end
   end
endmodule

// >>> hw/isp_pkg.sv
// Constants shared by the two-wire slave register port.
// Assumes a single system clock domain; the bus pins arrive asynchronously.
package isp_pkg;
   localparam logic [6:0] SLAVE_ADDR   = 7'h58;
   localparam int         BITS_PER_BYTE = 8;
   localparam int         REG_AW       = 8;
   localparam int         REG_DW       = 8;
   localparam int         NUM_REGS     = 256;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam int         CLK_HZ       = 50000000;
   localparam int         MAX_BIT_HZ   = 100000;
   // Data hold after SCL falls before SDA may change, in ns.
   localparam int         HOLD_NS      = 300;
   localparam int         CLK_NS       = 20;
   localparam int         HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] HOLD_CYC_W   = 4'(HOLD_CYC);
   localparam logic [3:0] BIT_LAST     = 4'h7;
   localparam logic [3:0] BIT_ACK      = 4'h8;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_RXREG = 3'b011,
      ST_RXDAT = 3'b010,
      ST_TX    = 3'b110,
      ST_IGN   = 3'b111
   } isp_state_t;
endpackage

// >>> hw/isp_sync.sv
// Two-flop synchroniser with edge detection for the bus pins.
// Assumes the pin is asynchronous to CLK.
`timescale 1ns/1ps
module isp_sync
(
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic CE,
   input  wire logic PIN,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic prev;

   // The first flop feeds only the second; edges come from stable flops.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end
      else if (CE)
      begin
         meta  <= PIN;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule

// >>> hw/isp_regfile.sv
// Byte-wide register store written and read by the serial port.
// Assumes writes come from the same clock domain.
`timescale 1ns/1ps
module isp_regfile
#(
   parameter int AW = isp_pkg::REG_AW,
   parameter int DW = isp_pkg::REG_DW
)
(
   input  wire logic          CLK,
   input  wire logic          RST_N,
   input  wire logic          CE,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Reset clears every byte so reads are defined before any write.
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         for (int i = 0; i < (1<<AW); i++)
            mem[i] <= DW'(isp_pkg::REG_RESET);
      end
      else if (CE && we)
      begin
         mem[addr] <= wdata;
      end
   end

   assign rdata = mem[addr];
endmodule

// >>> tb/isp_port_chk.sv
// Protocol checker for the two-wire slave port.
// Assumes it is bound to the port and sees only its pins.
`timescale 1ns/1ps
module isp_port_chk
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       CE,
   input wire logic       SCL_I,
   input wire logic       SDA_I,
   input wire logic       SDA_O,
   input wire logic       SDA_OE,
   input wire logic       BUSY,
   input wire logic       REG_WSTB,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   // Bus events; SCL must be settled high for both of them.
   sequence s_start;
      SCL_I && $past(SCL_I) && $fell(SDA_I);
   endsequence
   sequence s_stop;
      SCL_I && $past(SCL_I) && $rose(SDA_I);
   endsequence
   property p_start;
      s_start |-> ##[1:8] BUSY;
   endproperty
   property p_stop;
      s_stop |-> ##[1:8] !BUSY;
   endproperty
   property p_oe_rise;
      $rose(SDA_OE) |-> !SCL_I;
   endproperty
   property p_oe_stable;
      SCL_I && $past(SCL_I) |-> $stable(SDA_OE);
   endproperty
   property p_idle;
      !BUSY |-> !SDA_OE;
   endproperty
   property p_od;
      SDA_OE |-> SDA_O == 1'b0;
   endproperty
   property p_ack;
      REG_WSTB |-> ##[5:60] SDA_OE;
   endproperty
   property p_pulse;
      REG_WSTB |=> !REG_WSTB;
   endproperty
   property p_wbusy;
      REG_WSTB |-> BUSY;
   endproperty
   property p_freeze;
      !CE |=> $stable(SDA_OE) && $stable(BUSY) && $stable(REG_WSTB)
              && $stable(REG_ADDR);
   endproperty
   a_start: assert property (p_start) else $error("no busy after start");
   a_stop: assert property (p_stop) else $error("busy after stop");
   a_oe_rise: assert property (p_oe_rise) else $error("drive in high");
   a_oe_stable: assert property (p_oe_stable) else $error("sda moved");
   a_idle: assert property (p_idle) else $error("drive when idle");
   a_od: assert property (p_od) else $error("sda driven high");
   a_ack: assert property (p_ack) else $error("no data ack");
   a_pulse: assert property (p_pulse) else $error("long strobe");
   a_wbusy: assert property (p_wbusy) else $error("strobe idle");
   a_freeze: assert property (p_freeze) else $error("moved frozen");
endmodule
bind isp_port isp_port_chk chk_u (.CLK(CLK), .RST_N(RST_N), .CE(CE),
   .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .BUSY(BUSY), .REG_WSTB(REG_WSTB), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA));

// >>> tb/isp_master_bfm.sv
// Behavioural two-wire bus master.
// Assumes the bench resolves SDA as a wired AND with a pull-up.
`timescale 1ns/1ps
module isp_master_bfm
(
   input  wire logic clk,
   input  wire logic sda_in,
   output logic      scl,
   output logic      sda_drv
);
   int low_cyc = 32; // Low phase; the bench varies it to vary the rate.
   // The bus starts free with both lines high.
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // Every pin change lands on a falling CLK edge.
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One clock pulse per bit; SDA moves only while SCL is low.
   task automatic bit_slot(input logic b, output logic s);
      wt(2);
      sda_drv = b;
      wt(low_cyc);
      scl = 1'b1;
      s = sda_in;
      wt(4);
      scl = 1'b0;
   endtask
   // The long low wait lets the slave drop its acknowledge first.
   task automatic start();
      sda_drv = 1'b1;
      wt(low_cyc);
      scl = 1'b1;
      wt(4);
      sda_drv = 1'b0;
      wt(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      wt(2);
      sda_drv = 1'b0;
      wt(low_cyc);
      scl = 1'b1;
      wt(4);
      sda_drv = 1'b1;
      wt(4);
   endtask
   // Eight bits MSB first, then the ninth clock for the answer.
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(d[i], s);
      bit_slot(1'b1, ack);
   endtask
   task automatic recv(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(1'b1, d[i]);
      bit_slot(nack, s);
   endtask
endmodule

// >>> tb/isp_port_tb.sv
// Self-checking bench for the two-wire slave port.
// Assumes the master model drives the bus and SDA is wired AND.
`timescale 1ns/1ps
module isp_port_tb;
   logic        CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        ce = 1'b1;
   logic        scl;
   logic        sda_m;
   wire         sda_w;
   logic        SDA_O;
   logic        SDA_OE;
   logic        BUSY;
   logic        REG_WSTB;
   logic [7:0]  REG_ADDR;
   logic [7:0]  REG_WDATA;
   int          bad_count = 0;
   int          checks = 0;
   int          seed = 82474;
   logic [7:0]  mem [256];
   logic [15:0] wq [$];
   localparam logic [6:0] SA = isp_pkg::SLAVE_ADDR;
   // Pull-up: the line is low only when someone pulls it.
   assign sda_w = sda_m & ~(SDA_OE & ~SDA_O);
   initial
   begin
      forever #10 CLK = ~CLK;
   end
   isp_port dut_u (.CLK(CLK), .RST_N(RST_N), .CE(ce), .SCL_I(scl),
      .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .BUSY(BUSY),
      .REG_WSTB(REG_WSTB), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA));
   isp_master_bfm m_u (.clk(CLK), .sda_in(sda_w), .scl(scl), .sda_drv(sda_m));
   ////////////////////////////////////////////////////////////////////////
   // Record every register write the port reports.
   // Sampled mid-cycle so the strobe is settled and seen exactly once.
   always @(negedge CLK)
      if (REG_WSTB === 1'b1)
         wq.push_back({REG_ADDR, REG_WDATA});
   task automatic check(input string nm, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [15:0] exp_ack(input logic [6:0] a);
      return (a == SA) ? 16'h0 : 16'h1;
   endfunction
   // Write burst; a foreign address is refused and the master stops.
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input int n);
      logic       ack;
      logic [7:0] d;
      m_u.low_cyc = 30 + $unsigned($random(seed)) % 12;
      m_u.start();
      m_u.send({a, 1'b0}, ack);
      check("addr ack", 16'(ack), exp_ack(a));
      // A refused address is answered at once by a STOP.
      if (a == SA)
      begin
         m_u.send(r, ack);
         check("reg ack", 16'(ack), exp_ack(a));
         for (int k = 0; k < n; k++)
         begin
            d = 8'($random(seed));
            m_u.send(d, ack);
            check("data ack", 16'(ack), exp_ack(a));
            mem[8'(r + k)] = d;
         end
      end
      m_u.stop();
      m_u.wt(8);
      check("writes", 16'(wq.size()), 16'((a == SA) ? n : 0));
      for (int k = 0; k < n && wq.size() > 0; k++)
         check("wdata", wq.pop_front(), {8'(r + k), mem[8'(r + k)]});
   endtask
   // Set the pointer, restart, read n bytes, NACK the last.
   task automatic rd(input logic [7:0] r, input int n);
      logic       ack;
      logic [7:0] d;
      m_u.start();
      m_u.send({SA, 1'b0}, ack);
      m_u.send(r, ack);
      m_u.start();
      m_u.send({SA, 1'b1}, ack);
      check("rd ack", 16'(ack), 16'h0);
      for (int k = 0; k < n; k++)
      begin
         m_u.recv(k == n - 1, d);
         check("rdata", 16'(d), 16'(mem[8'(r + k)]));
      end
      m_u.stop();
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Main sequence: reset values, wrap corner, then random traffic.
   initial
   begin
      logic [7:0] a;
      foreach (mem[i])
         mem[i] = isp_pkg::REG_RESET;
      repeat (4) @(negedge CLK);
      RST_N = 1'b1;
      m_u.wt(4);
      check("idle", 16'({BUSY, SDA_OE, REG_WSTB}), 16'h0);
      // Freeze inside a transfer; the master pauses with SCL low.
      m_u.start();
      ce = 1'b0;
      m_u.wt(10);
      check("freeze", 16'({BUSY, REG_WSTB}), 16'h2);
      ce = 1'b1;
      m_u.stop();
      m_u.wt(4);
      rd(8'hFF, 2);
      wr(SA, 8'hFF, 2);
      rd(8'hFF, 2);
      for (int i = 0; i < 6; i++)
      begin
         a = 8'($random(seed));
         wr((a[6:0] == SA) ? 7'h59 : a[6:0], 8'h10, 1);
         a = 8'($random(seed));
         wr(SA, a, 1 + i % 3);
         rd(a, 2);
      end
      summarize();
   end
   // Cut a hang short well beyond the expected run time.
   initial
   begin
      repeat (60000) @(posedge CLK);
      bad_count++;
      summarize();
   end
endmodule
